/* File: rtl/srrs_pkg.sv */
// Shared constants for the serial readback register select block.
// Assumes a 16-bit serial frame, most significant bit first.
package srrs_pkg;

    // ==========================================================
    // Frame layout
    // ==========================================================
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned DATA_BITS = 9;
    localparam int unsigned CODE_BITS = 4;
    localparam int unsigned IDX_BITS = 4;

    // Fields of a received word
    localparam int unsigned SI_WATCHDOG_POS = 15;
    localparam int unsigned SI_BANK_POS = 13;
    localparam int unsigned SI_REGSEL_HI = 12;
    localparam int unsigned SI_REGSEL_LO = 10;
    localparam int unsigned SI_ADDR_HI = 2;
    localparam int unsigned SI_ADDR_LO = 0;

    // Register-select field value that marks an addressing word
    localparam logic [2:0] SI_ADDRESSING_SEL = 3'h0;

    // Fields of a transmitted word
    localparam int unsigned SO_WATCHDOG_POS = 15;
    localparam int unsigned SO_PARITY_POS = 14;
    localparam int unsigned SO_CODE_HI = 13;
    localparam int unsigned SO_CODE_LO = 10;
    localparam int unsigned SO_NORMAL_POS = 9;

    // ==========================================================
    // Readback select codes (low three bits; bank bit on top)
    // ==========================================================
    localparam logic [2:0] SEL_STATUS = 3'h0;
    localparam logic [2:0] SEL_FAULT = 3'h1;
    localparam logic [2:0] SEL_PWM = 3'h2;
    localparam logic [2:0] SEL_CONFIG = 3'h3;
    localparam logic [2:0] SEL_OVERCURRENT = 3'h4;
    localparam logic [2:0] SEL_RETRY = 3'h5;
    localparam logic [2:0] SEL_GLOBAL = 3'h6;
    localparam logic [2:0] SEL_DIAG = 3'h7;

    // ==========================================================
    // Readback data fields
    // ==========================================================
    localparam int unsigned RETRY_OFP_POS = 8;
    localparam int unsigned RETRY_CNT_HI = 7;
    localparam int unsigned RETRY_CNT_LO = 4;
    localparam int unsigned DIAG_PROF1_POS = 8;
    localparam int unsigned DIAG_PROF0_POS = 7;
    localparam int unsigned DIAG_ID_HI = 6;
    localparam int unsigned DIAG_ID_LO = 5;
    localparam int unsigned DIAG_IN1_POS = 4;
    localparam int unsigned DIAG_IN0_POS = 3;
    localparam int unsigned DIAG_CLKERR_POS = 2;
    localparam int unsigned DIAG_CAL1_POS = 1;
    localparam int unsigned DIAG_CAL0_POS = 0;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [3:0] RST_CODE = 4'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Frame state
    typedef enum logic [1:0] {
        SRRS_IDLE = 2'b00,
        SRRS_FRAME = 2'b01,
        SRRS_CLOSE = 2'b11
    } srrs_state_e;

endpackage

/* File: rtl/srrs_link.sv */
// Link-side logic of the readback block, clocked by the serial clock.
// Assumes chip select high resets the frame; serial clock idles low.
`timescale 1ns/100ps
module srrs_link
(
    input wire logic i_sys_rst,
    input wire logic i_sck,
    input wire logic i_csb,
    input wire logic i_si,
    output logic [15:0] o_rx_word,
    output logic o_rx_toggle,
    output logic o_over_toggle,
    output logic [3:0] o_fall_gray
);

    // ==========================================================
    // Receive on rising edges
    // ==========================================================
    logic [14:0] shift;
    logic [4:0] rise_cnt;
    logic [3:0] fall_bin;
    logic [3:0] next_fall_bin;

    // Chip select high clears the frame counters
    always_ff @(posedge i_sck or posedge i_csb)
    begin
        if (i_csb)
        begin
            shift <= 15'h0000;
            rise_cnt <= 5'h00;
        end
        else
        begin
            shift <= {shift[13:0], i_si};
            if (rise_cnt != 5'h11)
                rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // Word and event toggles survive between frames
    always_ff @(posedge i_sck or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_rx_word <= 16'h0000;
            o_rx_toggle <= 1'b0;
            o_over_toggle <= 1'b0;
        end
        else if (!i_csb)
        begin
            if (rise_cnt == 5'h0f)
            begin
                o_rx_word <= {shift, i_si};
                o_rx_toggle <= ~o_rx_toggle;
            end
            if (rise_cnt == 5'h10)
                o_over_toggle <= ~o_over_toggle; // Too many bits
        end
    end

    // ==========================================================
    // Falling-edge index, gray coded for the crossing
    // ==========================================================
    assign next_fall_bin = (fall_bin == 4'hf) ? fall_bin : fall_bin + 4'h1;

    always_ff @(negedge i_sck or posedge i_csb)
    begin
        if (i_csb)
        begin
            fall_bin <= 4'h0;
            o_fall_gray <= 4'h0;
        end
        else
        begin
            fall_bin <= next_fall_bin;
            o_fall_gray <= next_fall_bin ^ (next_fall_bin >> 1);
        end
    end

endmodule

/* File: rtl/srrs_readback.sv */
// Serial readback register select: builds the output word of each frame.
// Assumes channel state inputs come from logic on i_clk_sys; the serial
// pins and direct inputs arrive asynchronously.
//
// How it works
// R1: Channel registers come from bank chosen by bank bit
// R2: Retry readback top bit holds offset-positive flag
// R3: Retry bits seven to four show live counter
// R4: Code 0110 returns global configuration, bank ignored
// R5: Diagnostic bits eight, seven give load profiles
// R6: Diagnostic bits six, five hold product code
// R7: Diagnostic bits four, three show direct inputs
// R8: Diagnostic bit two flags external clock error while the external clock is in use
// R9: Diagnostic bits one, zero flag calibration failures
// R10: Selected data appears in the following frame
// R11: Invalid frame keeps last good selection
// R12: Upper bits carry watchdog, parity, echo, normal
// R13: Reading never alters contents or live status
`timescale 1ns/100ps
module srrs_readback
#(
    parameter logic [1:0] PRODUCT_ID = 2'h2 // Arbitrary value
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_sck,
    input wire logic i_csb,
    input wire logic i_si,
    input wire logic [8:0] i_pwm_ch0,
    input wire logic [8:0] i_pwm_ch1,
    input wire logic [8:0] i_config_ch0,
    input wire logic [8:0] i_config_ch1,
    input wire logic [8:0] i_overcurrent_ch0,
    input wire logic [8:0] i_overcurrent_ch1,
    input wire logic [8:0] i_global_config,
    input wire logic [1:0] i_offset_positive_flag,
    input wire logic [3:0] i_retry_count_ch0,
    input wire logic [3:0] i_retry_count_ch1,
    input wire logic i_ch0_load_profile,
    input wire logic i_ch1_load_profile,
    input wire logic [1:0] i_direct_in,
    input wire logic i_clock_internal,
    input wire logic i_ext_clock_error,
    input wire logic [1:0] i_cal_fail,
    input wire logic i_normal_mode,
    output logic o_so,
    output logic o_so_oe,
    output logic [3:0] o_readback_select_code,
    output logic o_parity_fault_flag,
    output logic o_frame_valid
);

    // ==========================================================
    // Link side
    // ==========================================================
    logic [15:0] rx_word;
    logic rx_toggle;
    logic over_toggle;
    logic [3:0] fall_gray;

    srrs_link u_link
    (
        .i_sys_rst(i_sys_rst),
        .i_sck(i_sck),
        .i_csb(i_csb),
        .i_si(i_si),
        .o_rx_word(rx_word),
        .o_rx_toggle(rx_toggle),
        .o_over_toggle(over_toggle),
        .o_fall_gray(fall_gray)
    );

    // ==========================================================
    // Crossings into the system clock
    // ==========================================================
    logic csb_meta;
    logic csb_sync;
    logic [1:0] din_meta;
    logic [1:0] din_sync;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic over_meta;
    logic over_sync;
    logic over_prev;
    logic [3:0] gray_meta;
    logic [3:0] gray_sync;

    // Two flops per crossing; the first stage feeds only the second.
    // The word is stable once its toggle is seen; the gray index moves
    // one bit at a time, so a torn sample is off by one at most
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            csb_meta <= 1'b1;
            csb_sync <= 1'b1;
            din_meta <= 2'h0;
            din_sync <= 2'h0;
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
            rx_prev <= 1'b0;
            over_meta <= 1'b0;
            over_sync <= 1'b0;
            over_prev <= 1'b0;
            gray_meta <= 4'h0;
            gray_sync <= 4'h0;
        end
        else
        begin
            csb_meta <= i_csb;
            csb_sync <= csb_meta;
            din_meta <= i_direct_in;
            din_sync <= din_meta;
            rx_meta <= rx_toggle;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
            over_meta <= over_toggle;
            over_sync <= over_meta;
            over_prev <= over_sync;
            gray_meta <= fall_gray;
            gray_sync <= gray_meta;
        end
    end

    function automatic logic [3:0] gray_to_bin(input logic [3:0] g);
        logic [3:0] b;
        b[3] = g[3];
        b[2] = b[3] ^ g[2];
        b[1] = b[2] ^ g[1];
        b[0] = b[1] ^ g[0];
        return b;
    endfunction

    // ==========================================================
    // Frame tracking
    // ==========================================================
    srrs_pkg::srrs_state_e state;
    logic rx_event;
    logic over_event;
    logic got_word;
    logic got_extra;
    logic word_ok;
    logic parity_bad;
    logic addressing;

    assign rx_event = rx_sync ^ rx_prev;
    assign over_event = over_sync ^ over_prev;
    // Exactly sixteen bits make a valid frame
    assign word_ok = (got_word | rx_event) & ~(got_extra | over_event);
    // Odd parity over the whole word is expected
    assign parity_bad = ~(^rx_word);
    assign addressing = rx_word[srrs_pkg::SI_REGSEL_HI:
        srrs_pkg::SI_REGSEL_LO] == srrs_pkg::SI_ADDRESSING_SEL;

    // Frame state: opens on select low, closes one cycle after release
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            state <= srrs_pkg::SRRS_IDLE;
        else
        begin
            case (state)
                srrs_pkg::SRRS_IDLE:
                    if (!csb_sync)
                        state <= srrs_pkg::SRRS_FRAME;
                srrs_pkg::SRRS_FRAME:
                    if (csb_sync)
                        state <= srrs_pkg::SRRS_CLOSE;
                srrs_pkg::SRRS_CLOSE:
                    state <= srrs_pkg::SRRS_IDLE;
                default:
                    state <= srrs_pkg::SRRS_IDLE;
            endcase
        end
    end

    // Bits seen in the current frame
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            got_word <= 1'b0;
            got_extra <= 1'b0;
        end
        else if (state == srrs_pkg::SRRS_IDLE)
        begin
            got_word <= 1'b0;
            got_extra <= 1'b0;
        end
        else
        begin
            if (rx_event)
                got_word <= 1'b1;
            if (over_event)
                got_extra <= 1'b1;
        end
    end

    // ==========================================================
    // Selection and status bits taken at frame close
    // ==========================================================
    logic watchdog_prev;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_readback_select_code <= srrs_pkg::RST_CODE;
            o_parity_fault_flag <= 1'b0;
            o_frame_valid <= 1'b0;
            watchdog_prev <= 1'b0;
        end
        else if (state == srrs_pkg::SRRS_CLOSE)
        begin
            o_frame_valid <= word_ok;
            if (word_ok)
            begin
                watchdog_prev <= rx_word[srrs_pkg::SI_WATCHDOG_POS]; // R12
                o_parity_fault_flag <= parity_bad; // R12
                // A bad frame leaves the last good selection standing
                if (!parity_bad && addressing)
                    o_readback_select_code <= {
                        rx_word[srrs_pkg::SI_BANK_POS],
                        rx_word[srrs_pkg::SI_ADDR_HI:srrs_pkg::SI_ADDR_LO]
                    }; // R11
            end
        end
    end

    // ==========================================================
    // Readback data multiplexer
    // ==========================================================
    logic bank;
    logic [2:0] sel_low;
    logic [8:0] next_data;
    logic [8:0] retry_view;
    logic [8:0] diag_view;

    assign bank = o_readback_select_code[3];
    assign sel_low = o_readback_select_code[2:0];

    // Retry view of the chosen bank; low bits read as zero
    always_comb
    begin
        retry_view = 9'h000;
        retry_view[srrs_pkg::RETRY_OFP_POS] =
            i_offset_positive_flag[bank]; // R2
        retry_view[srrs_pkg::RETRY_CNT_HI:srrs_pkg::RETRY_CNT_LO] =
            bank ? i_retry_count_ch1 : i_retry_count_ch0; // R3
    end

    // Diagnostic view is shared by both banks
    always_comb
    begin
        diag_view = 9'h000;
        diag_view[srrs_pkg::DIAG_PROF1_POS] = i_ch1_load_profile; // R5
        diag_view[srrs_pkg::DIAG_PROF0_POS] = i_ch0_load_profile; // R5
        diag_view[srrs_pkg::DIAG_ID_HI:srrs_pkg::DIAG_ID_LO] =
            PRODUCT_ID; // R6
        diag_view[srrs_pkg::DIAG_IN1_POS] = din_sync[1]; // R7
        diag_view[srrs_pkg::DIAG_IN0_POS] = din_sync[0]; // R7
        // Clock error only counts while the external clock is in use
        diag_view[srrs_pkg::DIAG_CLKERR_POS] =
            i_ext_clock_error & ~i_clock_internal; // R8
        diag_view[srrs_pkg::DIAG_CAL1_POS] = i_cal_fail[1]; // R9
        diag_view[srrs_pkg::DIAG_CAL0_POS] = i_cal_fail[0]; // R9
    end

    // Pure selection: nothing here feeds back to the sources
    always_comb
    begin
        case (sel_low)
            srrs_pkg::SEL_PWM:
                next_data = bank ? i_pwm_ch1 : i_pwm_ch0; // R1
            srrs_pkg::SEL_CONFIG:
                next_data = bank ? i_config_ch1 : i_config_ch0; // R1
            srrs_pkg::SEL_OVERCURRENT:
                next_data = bank ? i_overcurrent_ch1
                                 : i_overcurrent_ch0; // R1
            srrs_pkg::SEL_RETRY:
                next_data = retry_view; // R1
            srrs_pkg::SEL_GLOBAL:
                next_data = i_global_config; // R4
            srrs_pkg::SEL_DIAG:
                next_data = diag_view;
            default:
                next_data = 9'h000; // Status and fault views live elsewhere
        endcase
    end

    // ==========================================================
    // Output word and serial output
    // ==========================================================
    logic [15:0] tx_word;
    logic [3:0] bit_idx;

    assign bit_idx = gray_to_bin(gray_sync);

    // Word follows live state between frames and freezes for the frame
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            tx_word <= srrs_pkg::RST_WORD;
        else if (state == srrs_pkg::SRRS_IDLE && csb_sync)
            tx_word <= {watchdog_prev, o_parity_fault_flag,
                        o_readback_select_code, i_normal_mode,
                        next_data}; // R10 R12 R13
    end

    // Falling-edge index picks the bit; latency is three system clocks, far
    // inside half a serial clock period
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end
        else
        begin
            o_so_oe <= ~csb_sync;
            if (csb_sync)
                o_so <= tx_word[15];
            else
                o_so <= tx_word[4'hf - bit_idx]; // R10
        end
    end

endmodule

/* File: test/srrs_readback_checker.sv */
// Port-level checks for the serial readback select block.
// Assumes it is bound onto srrs_readback; one system clock domain.
`timescale 1ns/100ps
module srrs_readback_checker
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_sck,
    input wire logic i_csb,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic [3:0] o_readback_select_code,
    input wire logic o_parity_fault_flag,
    input wire logic o_frame_valid
);
    // ==========================================================
    // Clocking
    // ==========================================================
    // Serial pins are async, so every bound below allows sync delay
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    // ==========================================================
    // Output driver and frame bookkeeping
    // ==========================================================
    a_drive_on_select: assert property ($fell(i_csb) |-> ##[1:5] o_so_oe)
        else $error("serial output not driven after select");
    a_release_on_idle: assert property ($rose(i_csb) |-> ##[1:5] !o_so_oe)
        else $error("serial output still driven after deselect");
    a_quiet_while_idle: assert property (i_csb [*6] |-> !o_so_oe)
        else $error("serial output driven between frames");
    a_so_after_fall: assert property (o_so_oe && $changed(o_so) |-> !i_sck)
        else $error("serial output moved while serial clock high");
    a_select_needs_good: assert property ($changed(o_readback_select_code)
        |-> o_frame_valid && !o_parity_fault_flag)
        else $error("selection changed on a bad frame");
    a_select_between_frames: assert property ($changed(o_readback_select_code)
        |-> i_csb && $past(i_csb, 2))
        else $error("selection changed inside a frame");
    a_parity_on_close: assert property ($changed(o_parity_fault_flag)
        |-> i_csb && o_frame_valid)
        else $error("parity flag changed outside a valid close");
    a_valid_on_close: assert property ($changed(o_frame_valid) |-> i_csb)
        else $error("frame valid flag changed inside a frame");
endmodule

bind srrs_readback srrs_readback_checker i_chk (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_sck(i_sck), .i_csb(i_csb), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_readback_select_code(o_readback_select_code),
    .o_parity_fault_flag(o_parity_fault_flag), .o_frame_valid(o_frame_valid));

/* File: test/srrs_host.sv */
// Behavioural serial host that frames words for the readback block.
// Assumes the caller starts a transfer just after a system clock edge.
`timescale 1ns/100ps
module srrs_host
(
    input wire logic i_so,
    output logic o_sck,
    output logic o_csb,
    output logic o_si
);
    // Contract top rate; a faster clock outruns the output's sync delay
    localparam time HALF = 60;

    // ==========================================================
    // Idle levels
    // ==========================================================
    initial
    begin
        o_sck = 1'b0;
        o_csb = 1'b1;
        o_si = 1'b0;
    end

    // One frame of n bits, most significant first; reply sampled on rise
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        logic [16:0] sh;
        sh = {w, ~w[0]};
        r = 16'h0000;
        #1;
        o_csb = 1'b0;
        o_si = sh[16];
        #40;
        for (int i = 0; i < n; i++)
        begin
            o_sck = 1'b1;
            r = {r[14:0], i_so};
            #HALF;
            o_sck = 1'b0;
            sh = {sh[15:0], 1'b0};
            o_si = sh[16];
            #HALF;
        end
        o_si = ~o_si; // Released line shows no stale value
        o_csb = 1'b1;
        #100;
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the serial readback select block.
// Assumes srrs_host drives the serial pins; bank inputs change between frames.
`timescale 1ns/100ps
module testbench;
    localparam logic [1:0] PID = 2'h3; // Arbitrary value
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic sck, csb, si, so, so_oe, pf, fv, p0, p1, cint, cerr, nm;
    logic [3:0] code, code_m;
    logic [8:0] pwm[2], cfg[2], oc[2];
    logic [3:0] cnt[2];
    logic [8:0] gcfg;
    logic [1:0] offset_positive_flag, din, cal;
    logic wd_m, pf_m;
    int mismatches = 0;
    int checked = 0;

    // ==========================================================
    // Clock, design and host
    // ==========================================================
    always #2.5 i_clk_sys = ~i_clk_sys;

    srrs_readback #(.PRODUCT_ID(PID)) i_srrs_readback (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_sck(sck),
        .i_csb(csb), .i_si(si), .i_pwm_ch0(pwm[0]), .i_pwm_ch1(pwm[1]),
        .i_config_ch0(cfg[0]), .i_config_ch1(cfg[1]),
        .i_overcurrent_ch0(oc[0]), .i_overcurrent_ch1(oc[1]),
        .i_global_config(gcfg), .i_offset_positive_flag(offset_positive_flag),
        .i_retry_count_ch0(cnt[0]), .i_retry_count_ch1(cnt[1]),
        .i_ch0_load_profile(p0), .i_ch1_load_profile(p1),
        .i_direct_in(din), .i_clock_internal(cint),
        .i_ext_clock_error(cerr), .i_cal_fail(cal), .i_normal_mode(nm),
        .o_so(so), .o_so_oe(so_oe), .o_readback_select_code(code),
        .o_parity_fault_flag(pf), .o_frame_valid(fv));

    srrs_host i_srrs_host (.i_so(so), .o_sck(sck), .o_csb(csb), .o_si(si));

    // ==========================================================
    // Expectations
    // ==========================================================
    // Data field for a selection; status and fault read zero here
    function automatic logic [8:0] exp_data(input logic [3:0] c);
        case (c[2:0])
            3'h2: return pwm[c[3]];
            3'h3: return cfg[c[3]];
            3'h4: return oc[c[3]];
            3'h5: return {offset_positive_flag[c[3]], cnt[c[3]], 4'h0};
            3'h6: return gcfg;
            3'h7: return {p1, p0, PID, din, cerr & ~cint, cal};
            default: return 9'h000;
        endcase
    endfunction

    // Word with odd parity over all bits unless bad is set
    function automatic logic [15:0] mk(logic [3:0] c, logic [2:0] sel,
                                       logic bad);
        logic [15:0] w;
        w = {1'($urandom), 1'b0, c[3], sel, 7'($urandom), c[2:0]};
        w[14] = ~(^w) ^ bad;
        return w;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    // New live values, driven just after a clock edge
    task automatic rnd();
        for (int b = 0; b < 2; b++)
        begin
            pwm[b] <= 9'($urandom);
            cfg[b] <= 9'($urandom);
            oc[b] <= 9'($urandom);
            cnt[b] <= 4'($urandom);
        end
        {gcfg, offset_positive_flag, din, cal} <= 15'($urandom);
        {p0, p1, cint, cerr, nm} <= 5'($urandom);
    endtask

    // One frame, reply compared for 16-bit frames only, then the close flags
    task automatic run(input logic [15:0] w, input int n);
        logic [15:0] r;
        logic [15:0] e;
        logic pe;
        e = {wd_m, pf_m, code_m, nm, exp_data(code_m)};
        i_srrs_host.xfer(w, n, r);
        if (n == 16)
        begin
            chk(r, e);
            pe = ~^w;
            wd_m = w[15];
            pf_m = pe;
            if (!pe && w[12:10] == 3'h0)
                code_m = {w[13], w[2:0]};
        end
        chk({15'h0, fv}, {15'h0, n == 16});
        chk({12'h0, code}, {12'h0, code_m});
        chk({15'h0, pf}, {15'h0, pf_m});
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    // ==========================================================
    initial
    begin
        wd_m = 1'b0;
        pf_m = 1'b0;
        code_m = 4'h0;
        void'($urandom(46530));
        rnd();
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        // Every code in both banks, sent three times to show reads leave no trace
        for (int c = 0; c < 16; c++)
        begin
            @(posedge i_clk_sys);
            rnd();
            repeat (5) @(posedge i_clk_sys);
            repeat (3) run(mk(4'(c), 3'h0, 1'b0), 16);
        end
        // Bad parity and short frame must keep the last good selection
        run(mk(4'h2, 3'h0, 1'b0), 16);
        run(mk(4'h7, 3'h0, 1'b1), 16);
        run(mk(4'he, 3'h0, 1'b0), 15);
        run(mk(4'hd, 3'h5, 1'b0), 16);
        run(mk(4'hd, 3'h0, 1'b0), 16);
        // Mid-run reset clears selection, flags, echo and serial output
        @(posedge i_clk_sys);
        i_sys_rst <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        chk({8'h00, so, so_oe, pf, fv, code}, 16'h0000);
        i_sys_rst <= 1'b0;
        wd_m = 1'b0;
        pf_m = 1'b0;
        code_m = 4'h0;
        repeat (5) @(posedge i_clk_sys);
        // Random words, lengths and non-addressing selects
        for (int i = 0; i < 40; i++)
        begin
            @(posedge i_clk_sys);
            rnd();
            repeat (5) @(posedge i_clk_sys);
            run(mk(4'($urandom), ($urandom_range(3) == 0) ?
                3'($urandom_range(7, 1)) : 3'h0, $urandom_range(4) == 0),
                ($urandom_range(3) == 0) ? 15 + 2 * $urandom_range(1) : 16);
        end
        print_verdict();
    end

    // A hung frame must not stall the run forever
    initial
    begin
        #400000;
        mismatches++;
        print_verdict();
    end
endmodule
